// ==== ctmc_pkg.sv ====
package ctmc_pkg;

    // Serial register addresses
    localparam logic [6:0] ADDR_MODE_CTRL   = 7'h01;
    localparam logic [6:0] ADDR_MAIN_STATUS = 7'h03;
    localparam logic [6:0] ADDR_CAN_CTRL    = 7'h20;
    localparam logic [6:0] ADDR_TRX_STATUS  = 7'h22;

    // Field positions
    localparam int FORCED_SLEEP_BIT = 7;
    localparam int OVERTEMP_BIT     = 6;
    localparam int NOT_NORMAL_BIT   = 5;
    localparam int CTS_BIT          = 7;

    // Operating mode codes
    localparam logic [2:0] OPM_SLEEP   = 3'h1;
    localparam logic [2:0] OPM_STANDBY = 3'h4;
    localparam logic [2:0] OPM_NORMAL  = 3'h7;

    // CAN mode codes
    localparam logic [1:0] CANSEL_OFFLINE   = 2'h0;
    localparam logic [1:0] CANSEL_ACTIVE_UV = 2'h1;
    localparam logic [1:0] CANSEL_ACTIVE    = 2'h2;
    localparam logic [1:0] CANSEL_LISTEN    = 2'h3;

    // Reset values
    localparam logic [1:0] CANSEL_RST       = 2'h0;
    localparam logic       NOT_NORMAL_RST   = 1'b1;
    localparam logic       FORCED_SLEEP_RST = 1'b0;

    // Serial frame: 7 address bits, read-only flag, 8 data bits
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] HDR_BITS   = 5'h08;

    // Timing
    localparam int CLK_PERIOD_NS     = 25;
    localparam int SILENCE_TIMEOUT_US = 1000;
    localparam int SILENCE_CYC =
        (SILENCE_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        DEV_STANDBY = 3'b001,
        DEV_NORMAL  = 3'b010,
        DEV_SLEEP   = 3'b100
    } ctmc_dev_mode_e;

    typedef enum logic [3:0] {
        CAN_OFFLINE = 4'b0001,
        CAN_OFFBIAS = 4'b0010,
        CAN_LISTEN  = 4'b0100,
        CAN_ACTIVE  = 4'b1000
    } ctmc_can_mode_e;

    typedef struct packed {
        logic scsn_n;
        logic sck;
        logic sdi;
    } ctmc_spi_in_s;

    typedef struct packed {
        logic vcc_uv;
        logic uv_sleep;
        logic overtemp_warn;
        logic wake_pending;
        logic wake_src_en;
        logic wake_event;
    } ctmc_sys_in_s;

    typedef struct packed {
        logic bus_rx;
        logic bus_edge;
    } ctmc_bus_in_s;

endpackage

// ==== ctmc_mode_ctrl.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Host writes the mode field of register 0x01 to pick operating mode.
// - Mode code 001 asks Sleep, 100 Standby, 111 Normal.
// - Main status bit 7 tells host-commanded (0) or undervoltage-forced (1) Sleep.
// - Main status bit 6 follows the overtemperature warning level.
// - Main status bit 5 is 1 after power-up until Normal first entered.
// - Active and Listen-only keep the bus biased to mid level.
// - Offline biases mid while bus active, ground after silence timeout.
// - Normal lets CAN mode pick sub-mode; Standby/Sleep force Offline/Offline Bias.
// - CAN mode 01 and 10 request Active: transmit and receive.
// - CAN mode 01 drops Active to Offline when transmitter supply is low.
// - CAN mode 10 ignores supply undervoltage until it forces Sleep.
// - Active only in Normal, CAN mode 01/10, and for 01 supply good.
// - Transmit input low at Active request gives Listen-only until it rises.
// - Transceiver status register shows whether CAN is ready.
// - Normal with CAN mode 11 gives Listen-only: no transmit, receive and bias on.
// - Listen-only holds while transmit input low or, in CAN mode 01, transmitter supply low.
// - Active drives receive output from bus and bus from transmit input.
// - Sleep request enters Sleep only if no wake pending and a source enabled.
// - Normal with CAN mode 00 goes Offline, via Offline Bias if bus recent.
module ctmc_mode_ctrl
    import ctmc_pkg::*;
#(
    parameter int SILENCE_CYCLES = ctmc_pkg::SILENCE_CYC
) (
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    // Serial register port
    input  wire ctmc_pkg::ctmc_spi_in_s  spi_in,
    output logic                         sdo,
    output logic                         sdo_oe,
    // Supply, temperature and wake status
    input  wire ctmc_pkg::ctmc_sys_in_s  sys_in,
    // Protocol controller side
    input  wire logic                    txd,
    output logic                         rxd,
    // Bus side
    input  wire ctmc_pkg::ctmc_bus_in_s  bus_in,
    output logic                         tx_dominant,
    output logic                         bias_mid,
    // Mode visibility
    output ctmc_pkg::ctmc_dev_mode_e     dev_mode,
    output ctmc_pkg::ctmc_can_mode_e     can_mode,
    output logic                         can_ready
);
    import ctmc_pkg::*;

    localparam int SIL_W = $clog2(SILENCE_CYCLES + 1);
    localparam logic [SIL_W-1:0] SIL_MAX = SIL_W'(SILENCE_CYCLES);

    // Serial port state
    logic        sck_q, next_sck_q;
    logic [4:0]  bit_cnt, next_bit_cnt;
    logic [15:0] rx_sh, next_rx_sh;
    logic [7:0]  tx_sh, next_tx_sh;
    logic        next_sdo;
    logic        wr_en, next_wr_en;
    logic [6:0]  wr_addr, next_wr_addr;
    logic [7:0]  wr_data, next_wr_data;
    logic        sck_rise, sck_fall;

    // Control and status state
    ctmc_dev_mode_e next_dev_mode;
    ctmc_can_mode_e next_can_mode;
    logic [1:0]     can_mode_select, next_can_mode_select;
    logic           forced_sleep_flag, next_forced_sleep_flag;
    logic           overtemp_warning_flag, next_overtemp_warning_flag;
    logic           normal_not_yet_entered, next_normal_not_yet_entered;
    logic [SIL_W-1:0] sil_cnt, next_sil_cnt;
    logic           bus_quiet;
    logic           next_rxd, next_tx_dominant, next_bias_mid;
    logic [2:0]     operating_mode_select;
    logic [7:0]     rd_data;

    assign sck_rise = spi_in.sck & ~sck_q;
    assign sck_fall = ~spi_in.sck & sck_q;
    assign sdo_oe   = ~spi_in.scsn_n;
    assign can_ready = (can_mode == CAN_ACTIVE);

    always_comb begin
        case (dev_mode)
            DEV_NORMAL: operating_mode_select = OPM_NORMAL;
            DEV_SLEEP:  operating_mode_select = OPM_SLEEP;
            default:    operating_mode_select = OPM_STANDBY;
        endcase
    end

    // Unmapped addresses and reserved bits read as zero
    always_comb begin
        rd_data = 8'h00;
        case (rx_sh[6:0])
            ADDR_MODE_CTRL:   rd_data[2:0] = operating_mode_select;
            ADDR_MAIN_STATUS: begin
                rd_data[FORCED_SLEEP_BIT] = forced_sleep_flag;
                rd_data[OVERTEMP_BIT]     = overtemp_warning_flag;
                rd_data[NOT_NORMAL_BIT]   = normal_not_yet_entered;
            end
            ADDR_CAN_CTRL:    rd_data[1:0] = can_mode_select;
            ADDR_TRX_STATUS:  rd_data[CTS_BIT] = can_ready;
            default:          rd_data = 8'h00;
        endcase
    end

    // Serial shifter: sample on rising SCK, shift out on falling SCK
    always_comb begin
        next_sck_q   = spi_in.sck;
        next_bit_cnt = bit_cnt;
        next_rx_sh   = rx_sh;
        next_tx_sh   = tx_sh;
        next_sdo     = sdo;
        next_wr_en   = 1'b0;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        if (spi_in.scsn_n) begin
            next_bit_cnt = 5'h00;
            next_sdo     = 1'b0;
        end else if (sck_rise) begin
            next_rx_sh = {rx_sh[14:0], spi_in.sdi};
            if (bit_cnt != FRAME_BITS) begin
                next_bit_cnt = bit_cnt + 5'h01;
            end
            if (bit_cnt == HDR_BITS - 5'h01) begin
                next_tx_sh = rd_data;
            end
            // Only a complete frame with a clear read-only flag writes
            if (bit_cnt == FRAME_BITS - 5'h01 && !rx_sh[7]) begin
                next_wr_en   = 1'b1;
                next_wr_addr = rx_sh[14:8];
                next_wr_data = {rx_sh[6:0], spi_in.sdi};
            end
        end else if (sck_fall && bit_cnt >= HDR_BITS
                     && bit_cnt < FRAME_BITS) begin
            next_sdo   = tx_sh[7];
            next_tx_sh = {tx_sh[6:0], 1'b0};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_q   <= 1'b0;
            bit_cnt <= 5'h00;
            rx_sh   <= 16'h0000;
            tx_sh   <= 8'h00;
            sdo     <= 1'b0;
            wr_en   <= 1'b0;
            wr_addr <= 7'h00;
            wr_data <= 8'h00;
        end else begin
            sck_q   <= next_sck_q;
            bit_cnt <= next_bit_cnt;
            rx_sh   <= next_rx_sh;
            tx_sh   <= next_tx_sh;
            sdo     <= next_sdo;
            wr_en   <= next_wr_en;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
        end
    end

    // Device operating mode; undervoltage outranks a host command
    always_comb begin
        next_dev_mode               = dev_mode;
        next_forced_sleep_flag      = forced_sleep_flag;
        next_normal_not_yet_entered = normal_not_yet_entered;
        next_can_mode_select        = can_mode_select;
        next_overtemp_warning_flag  = sys_in.overtemp_warn;
        if (wr_en && wr_addr == ADDR_CAN_CTRL) begin
            next_can_mode_select = wr_data[1:0];
        end
        if (dev_mode != DEV_SLEEP && sys_in.uv_sleep) begin
            next_dev_mode          = DEV_SLEEP;
            next_forced_sleep_flag = 1'b1;
        end else if (wr_en && wr_addr == ADDR_MODE_CTRL) begin
            case (wr_data[2:0])
                OPM_SLEEP: begin
                    if (!sys_in.wake_pending && sys_in.wake_src_en) begin
                        next_dev_mode          = DEV_SLEEP;
                        next_forced_sleep_flag = 1'b0;
                    end else begin
                        next_dev_mode = DEV_STANDBY;
                    end
                end
                OPM_STANDBY: next_dev_mode = DEV_STANDBY;
                OPM_NORMAL:  next_dev_mode = DEV_NORMAL;
                default:    next_dev_mode = dev_mode;
            endcase
        end else if (dev_mode == DEV_SLEEP && sys_in.wake_event) begin
            next_dev_mode = DEV_STANDBY;
        end
        if (next_dev_mode == DEV_NORMAL) begin
            next_normal_not_yet_entered = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dev_mode               <= DEV_STANDBY;
            forced_sleep_flag      <= FORCED_SLEEP_RST;
            normal_not_yet_entered <= NOT_NORMAL_RST;
            can_mode_select        <= CANSEL_RST;
            overtemp_warning_flag  <= 1'b0;
        end else begin
            dev_mode               <= next_dev_mode;
            forced_sleep_flag      <= next_forced_sleep_flag;
            normal_not_yet_entered <= next_normal_not_yet_entered;
            can_mode_select        <= next_can_mode_select;
            overtemp_warning_flag  <= next_overtemp_warning_flag;
        end
    end

    assign bus_quiet = (sil_cnt == SIL_MAX);

    // CAN sub-mode; TXD low blocks entry to Active, not staying in it
    always_comb begin
        next_can_mode = can_mode;
        next_sil_cnt  = bus_in.bus_edge ? '0
                      : (bus_quiet ? sil_cnt : sil_cnt + SIL_W'(1));
        if (dev_mode == DEV_NORMAL
            && (can_mode_select == CANSEL_ACTIVE_UV
                || can_mode_select == CANSEL_ACTIVE)) begin
            if (can_mode_select == CANSEL_ACTIVE_UV && sys_in.vcc_uv) begin
                if (can_mode == CAN_LISTEN) begin
                    next_can_mode = CAN_LISTEN;
                end else begin
                    next_can_mode = bus_quiet ? CAN_OFFLINE
                                              : CAN_OFFBIAS;
                end
            end else if (can_mode != CAN_ACTIVE && !txd) begin
                next_can_mode = CAN_LISTEN;
            end else begin
                next_can_mode = CAN_ACTIVE;
            end
        end else if (dev_mode == DEV_NORMAL
                     && can_mode_select == CANSEL_LISTEN) begin
            next_can_mode = CAN_LISTEN;
        end else begin
            // Standby, Sleep (incl. forced by supply loss) or CAN mode 00
            case (can_mode)
                CAN_OFFLINE: next_can_mode = bus_in.bus_edge ? CAN_OFFBIAS
                                                              : CAN_OFFLINE;
                CAN_OFFBIAS: next_can_mode = bus_quiet ? CAN_OFFLINE
                                                       : CAN_OFFBIAS;
                default:     next_can_mode = bus_quiet ? CAN_OFFLINE
                                                       : CAN_OFFBIAS;
            endcase
        end
        next_bias_mid    = (next_can_mode != CAN_OFFLINE);
        next_tx_dominant = (next_can_mode == CAN_ACTIVE) && !txd;
        next_rxd         = (next_can_mode == CAN_ACTIVE
                            || next_can_mode == CAN_LISTEN)
                           ? bus_in.bus_rx : 1'b1;
    end
    // mode 10 has no undervoltage branch; supply loss ends it only through forced Sleep

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            can_mode    <= CAN_OFFLINE;
            sil_cnt     <= SIL_MAX;
            bias_mid    <= 1'b0;
            tx_dominant <= 1'b0;
            rxd         <= 1'b1;
        end else begin
            can_mode    <= next_can_mode;
            sil_cnt     <= next_sil_cnt;
            bias_mid    <= next_bias_mid;
            tx_dominant <= next_tx_dominant;
            rxd         <= next_rxd;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_mode_wr(logic [2:0] code);
        wr_en && wr_addr == ADDR_MODE_CTRL && wr_data[2:0] == code
        && !(dev_mode != DEV_SLEEP && sys_in.uv_sleep);
    endsequence

    AST_MODE_NORMAL: assert property (
        s_mode_wr(OPM_NORMAL) |=> dev_mode == DEV_NORMAL
        ##0 !normal_not_yet_entered)
        else $error("normal command not taken");
    AST_SLEEP_GATE: assert property (
        s_mode_wr(OPM_SLEEP) ##0 (sys_in.wake_pending || !sys_in.wake_src_en)
        |=> dev_mode == DEV_STANDBY)
        else $error("blocked sleep request did not give standby");
    AST_FORCED_SLEEP: assert property (
        dev_mode != DEV_SLEEP && sys_in.uv_sleep
        |=> dev_mode == DEV_SLEEP && forced_sleep_flag)
        else $error("undervoltage sleep not flagged");
    AST_OVERTEMP: assert property (
        $rose(sys_in.overtemp_warn) |=> overtemp_warning_flag)
        else $error("overtemp warning not reported");
    AST_NOT_YET_NORMAL: assert property (
        dev_mode == DEV_NORMAL |-> !normal_not_yet_entered)
        else $error("normal status still pending in normal");
    AST_BIAS: assert property (
        can_mode == CAN_ACTIVE || can_mode == CAN_LISTEN |-> bias_mid)
        else $error("bus not biased mid while receiving");
    AST_NOT_NORMAL: assert property (
        dev_mode != DEV_NORMAL
        |=> can_mode == CAN_OFFLINE || can_mode == CAN_OFFBIAS)
        else $error("transceiver on outside normal");
    AST_UV_DROP: assert property (
        dev_mode == DEV_NORMAL && can_mode == CAN_ACTIVE
        && can_mode_select == CANSEL_ACTIVE_UV && sys_in.vcc_uv
        |=> can_mode == CAN_OFFLINE || can_mode == CAN_OFFBIAS)
        else $error("active kept under supply undervoltage");
    AST_ACTIVE_ENTRY: assert property (
        $rose(can_mode == CAN_ACTIVE) |-> $past(dev_mode == DEV_NORMAL
        && (can_mode_select == CANSEL_ACTIVE
            || (can_mode_select == CANSEL_ACTIVE_UV && !sys_in.vcc_uv))))
        else $error("active entered without its conditions");
    AST_TXD_BLOCK: assert property (
        can_mode != CAN_ACTIVE && !txd |=> can_mode != CAN_ACTIVE)
        else $error("active entered with transmit input low");
    AST_LISTEN11: assert property (
        dev_mode == DEV_NORMAL && can_mode_select == CANSEL_LISTEN
        |=> can_mode == CAN_LISTEN ##0 !tx_dominant)
        else $error("listen-only not selected");
    AST_TX_FOLLOW: assert property (
        can_mode == CAN_ACTIVE ##1 can_mode == CAN_ACTIVE
        |-> tx_dominant == !$past(txd))
        else $error("bus drive does not follow transmit input");
    AST_SILENCE: assert property (
        can_mode == CAN_OFFBIAS && dev_mode != DEV_NORMAL && bus_quiet
        |=> can_mode == CAN_OFFLINE ##0 !bias_mid)
        else $error("offline bias kept after silence");

endmodule

// ==== ctmc_spi_host.sv ====
`timescale 1ns/1ps
module ctmc_spi_host (
    // Clock
    input  wire logic              ref_clk,
    // Serial register port
    output ctmc_pkg::ctmc_spi_in_s spi_out,
    input  wire logic              sdo
);
    import ctmc_pkg::*;

    initial begin
        spi_out = '{scsn_n: 1'b1, sck: 1'b0, sdi: 1'b0};
    end

    // Mode 0, MSB first; three slow cycles low give sdo time to settle
    task automatic xfer(input logic [6:0] addr, input logic rd,
                        input logic [7:0] wdata, output logic [7:0] rdata);
        logic [15:0] frame;
        frame = {addr, rd, wdata};
        rdata = 8'h00;
        @(negedge ref_clk);
        spi_out.scsn_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spi_out.sdi = frame[i];
            repeat (3) @(negedge ref_clk);
            if (i < 8) begin
                rdata[i] = sdo;
            end
            spi_out.sck = 1'b1;
            repeat (2) @(negedge ref_clk);
            spi_out.sck = 1'b0;
        end
        repeat (3) @(negedge ref_clk);
        spi_out.scsn_n = 1'b1;
        // A released data line must not keep showing the last bit
        spi_out.sdi = ~spi_out.sdi;
    endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
    import ctmc_pkg::*;
    localparam int SIL = 8;

    logic           ref_clk    = 1'b0;
    logic           rst_n      = 1'b0;
    logic           txd        = 1'b1;
    logic           edges_on   = 1'b0;
    ctmc_sys_in_s   sys        = '0;
    logic           bus_rx     = 1'b1;
    logic           bus_edge   = 1'b0;
    ctmc_bus_in_s   bus;
    ctmc_spi_in_s   spi;
    logic           sdo;
    logic           sdo_oe;
    logic           rxd;
    logic           tx_dominant;
    logic           bias_mid;
    logic           can_ready;
    ctmc_dev_mode_e dev_mode;
    ctmc_can_mode_e can_mode;
    int             errors     = 0;
    int             n_compared = 0;
    logic [7:0]     rd;
    logic [2:0]     undef [5]  = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h6};

    always #12.5 ref_clk = ~ref_clk;

    // Bus edge pulses on alternate cycles while activity is wanted
    always @(negedge ref_clk) begin
        bus_edge <= edges_on & ~bus_edge;
    end

    assign bus = '{bus_rx: bus_rx, bus_edge: bus_edge};

    ctmc_spi_host i_host (
        .ref_clk (ref_clk),
        .spi_out (spi),
        .sdo     (sdo)
    );

    ctmc_mode_ctrl #(
        .SILENCE_CYCLES (SIL)
    ) i_dut (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .spi_in      (spi),
        .sdo         (sdo),
        .sdo_oe      (sdo_oe),
        .sys_in      (sys),
        .txd         (txd),
        .rxd         (rxd),
        .bus_in      (bus),
        .tx_dominant (tx_dominant),
        .bias_mid    (bias_mid),
        .dev_mode    (dev_mode),
        .can_mode    (can_mode),
        .can_ready   (can_ready)
    );

    function automatic logic [7:0] exp_status(input logic f, input logic o,
                                              input logic n);
        exp_status = 8'h00;
        exp_status[FORCED_SLEEP_BIT] = f;
        exp_status[OVERTEMP_BIT] = o;
        exp_status[NOT_NORMAL_BIT] = n;
    endfunction

    task automatic conclude();
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic fail(input logic [7:0] got, input logic [7:0] exp);
        errors++;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) fail(got, exp);
    endtask

    task automatic chk_can(input ctmc_can_mode_e exp);
        n_compared++;
        if (can_mode !== exp) fail({4'h0, can_mode}, {4'h0, exp});
    endtask

    // Mode changes are polled under a bound; running out ends the run
    task automatic chk_dev(input ctmc_dev_mode_e exp);
        n_compared++;
        for (int k = 0; k < 8 && dev_mode !== exp; k++) @(negedge ref_clk);
        if (dev_mode !== exp) begin
            fail({5'h00, dev_mode}, {5'h00, exp});
            conclude();
        end
    endtask

    task automatic wr(input logic [6:0] addr, input logic [7:0] data);
        i_host.xfer(addr, 1'b0, data, rd);
        repeat (4) @(negedge ref_clk);
    endtask

    task automatic rd_chk(input logic [6:0] addr, input logic [7:0] exp);
        i_host.xfer(addr, 1'b1, 8'h00, rd);
        chk_byte(rd, exp);
    endtask

    task automatic settle();
        repeat (3) @(negedge ref_clk);
    endtask

    initial begin
        void'($urandom(32'h883b));
        repeat (6) @(negedge ref_clk);
        rst_n = 1'b1;
        chk_can(CAN_OFFLINE);
        chk_byte({7'h00, bias_mid}, 8'h00);
        chk_byte({7'h00, sdo_oe}, 8'h00);
        rd_chk(ADDR_MAIN_STATUS, exp_status(1'b0, 1'b0, 1'b1));
        sys.overtemp_warn = 1'b1;
        rd_chk(ADDR_MAIN_STATUS, exp_status(1'b0, 1'b1, 1'b1));
        sys.overtemp_warn = 1'b0;
        rd_chk(ADDR_MAIN_STATUS, exp_status(1'b0, 1'b0, 1'b1));
        foreach (undef[i]) begin
            wr(ADDR_MODE_CTRL, {5'($urandom), undef[i]});
            rd_chk(ADDR_MODE_CTRL, {5'h00, OPM_STANDBY});
        end
        chk_dev(DEV_STANDBY);
        rd_chk(7'h55, 8'h00);
        wr(ADDR_MODE_CTRL, {5'h00, OPM_NORMAL});
        chk_dev(DEV_NORMAL);
        rd_chk(ADDR_MAIN_STATUS, exp_status(1'b0, 1'b0, 1'b0));
        txd = 1'b0;
        wr(ADDR_CAN_CTRL, {6'h00, CANSEL_ACTIVE});
        chk_can(CAN_LISTEN);
        chk_byte({7'h00, tx_dominant}, 8'h00);
        chk_byte({7'h00, can_ready}, 8'h00);
        txd = 1'b1;
        settle();
        chk_can(CAN_ACTIVE);
        chk_byte({7'h00, can_ready}, 8'h01);
        rd_chk(ADDR_TRX_STATUS, 8'h01 << CTS_BIT);
        for (int i = 0; i < 24; i++) begin
            txd = 1'($urandom);
            bus_rx = 1'($urandom);
            @(negedge ref_clk);
            chk_byte({6'h0, rxd, tx_dominant}, {6'h0, bus_rx, ~txd});
        end
        txd = 1'b1;
        chk_byte({7'h00, bias_mid}, 8'h01);
        sys.vcc_uv = 1'b1;
        settle();
        chk_can(CAN_ACTIVE);
        sys.vcc_uv = 1'b0;
        wr(ADDR_CAN_CTRL, {6'h00, CANSEL_ACTIVE_UV});
        sys.vcc_uv = 1'b1;
        settle();
        chk_can(CAN_OFFLINE);
        sys.vcc_uv = 1'b0;
        txd = 1'b0;
        settle();
        chk_can(CAN_LISTEN);
        sys.vcc_uv = 1'b1;
        txd = 1'b1;
        settle();
        chk_can(CAN_LISTEN);
        sys.vcc_uv = 1'b0;
        settle();
        chk_can(CAN_ACTIVE);
        txd = 1'b0;
        wr(ADDR_CAN_CTRL, {6'h00, CANSEL_LISTEN});
        chk_can(CAN_LISTEN);
        chk_byte({6'h00, bias_mid, tx_dominant}, 8'h02);
        txd = 1'b1;
        edges_on = 1'b1;
        wr(ADDR_CAN_CTRL, {6'h00, CANSEL_OFFLINE});
        chk_can(CAN_OFFBIAS);
        chk_byte({7'h00, bias_mid}, 8'h01);
        edges_on = 1'b0;
        repeat (SIL / 2) @(negedge ref_clk);
        chk_can(CAN_OFFBIAS);
        repeat (SIL + 2) @(negedge ref_clk);
        chk_can(CAN_OFFLINE);
        chk_byte({7'h00, bias_mid}, 8'h00);
        sys.wake_src_en = 1'b1;
        sys.wake_pending = 1'b1;
        wr(ADDR_MODE_CTRL, {5'h00, OPM_SLEEP});
        chk_dev(DEV_STANDBY);
        sys.wake_pending = 1'b0;
        wr(ADDR_MODE_CTRL, {5'h00, OPM_SLEEP});
        chk_dev(DEV_SLEEP);
        rd_chk(ADDR_MODE_CTRL, {5'h00, OPM_SLEEP});
        rd_chk(ADDR_MAIN_STATUS, exp_status(1'b0, 1'b0, 1'b0));
        edges_on = 1'b1;
        settle();
        chk_can(CAN_OFFBIAS);
        edges_on = 1'b0;
        sys.wake_event = 1'b1;
        @(negedge ref_clk);
        sys.wake_event = 1'b0;
        wr(ADDR_MODE_CTRL, {5'h00, OPM_NORMAL});
        wr(ADDR_CAN_CTRL, {6'h00, CANSEL_ACTIVE});
        chk_can(CAN_ACTIVE);
        sys.vcc_uv = 1'b1;
        sys.uv_sleep = 1'b1;
        chk_dev(DEV_SLEEP);
        settle();
        chk_can(CAN_OFFLINE);
        rd_chk(ADDR_MAIN_STATUS, exp_status(1'b1, 1'b0, 1'b0));
        sys.uv_sleep = 1'b0;
        sys.vcc_uv = 1'b0;
        rst_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        chk_dev(DEV_STANDBY);
        rd_chk(ADDR_MAIN_STATUS, exp_status(1'b0, 1'b0, 1'b1));
        conclude();
    end
endmodule
